// >>> section_trace_processor.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Length bit selects 16 or 64 bytes
// - Short aligned: msb-set byte goes first
// - Long aligned: byte after CR LF first
// - Alignment off gives plain circular capture
// - Zero bit sends all-zero trace bytes
// - Otherwise send transmit buffer contents
// - Accept after five or three repeats
// - Mismatch change raises interrupt when enabled
// - Stability change raises interrupt when enabled
// - Select bit picks receive or transmit buffer
// - Zero messages count only when enabled
// - Mismatch state shows accepted differs expected
// - Mismatch change flag, cleared on read
// - Unstable after eight changed messages, cleared accept
// - Unstable change flag, cleared on read
// - Busy from address write for 0.6 us
// - Receive pages 0-63 captured, 64-127 expected
// - Address write starts read or write
module section_trace_processor
   import trace_pkg::*;
(
   input  wire logic       sys_clk_i,    // System clock
   input  wire logic       rst_i,        // Synchronous reset, active high
   input  wire logic [7:0] reg_addr_i,   // Register address
   input  wire logic [7:0] reg_wdata_i,  // Register write data
   input  wire logic       reg_wr_i,     // Write strobe
   input  wire logic       reg_rd_i,     // Read strobe
   output logic      [7:0] reg_rdata_o,  // Read data, cycle after strobe
   input  wire logic [7:0] rx_byte_i,    // Received trace byte
   input  wire logic       rx_valid_i,   // Received byte strobe
   input  wire logic       tx_req_i,     // Transmit byte request
   output logic      [7:0] tx_byte_o,    // Outgoing trace byte
   output logic            tx_valid_o,   // Outgoing byte strobe
   output logic            trace_mismatch_defect_o, // Mismatch state
   output logic            irq_out_n_o   // Interrupt, active low
);

   // Trace buffers
   logic [7:0] cap_mem [64];            // Captured message page
   logic [7:0] exp_mem [64];            // Expected message page
   logic [7:0] tx_mem  [64];            // Transmit message

   ctrl_t      ctrl_r;                  // Control register
   ind_addr_t  ind_addr_r;              // Indirect address register
   logic [7:0] ind_data_r;              // Indirect data register
   logic       busy_r;                  // Indirect access pending
   logic [6:0] busy_cnt_r;              // Cycles left in access
   logic [5:0] wptr_r;                  // Next capture location
   logic [7:0] prev1_r, prev2_r;        // Last two received bytes
   logic       started_r;               // A message is in progress
   logic       acc_diff_prev_r;         // Message differs from previous
   logic       acc_diff_exp_r;          // Message differs from expected
   logic       acc_nonzero_r;           // Message holds a nonzero byte
   logic [2:0] rep_cnt_r;               // Identical repeats seen
   logic [3:0] chg_cnt_r;               // Consecutive changed messages
   logic       mis_state_r, mis_flag_r; // Mismatch state and change flag
   logic       uns_state_r, uns_flag_r; // Unstable state and change flag
   logic [5:0] tx_ptr_r;                // Next transmit location

   logic [5:0] len_last;                // Last index of message
   logic [5:0] idx;                     // Location of arriving byte
   logic       msg_start, msg_done;     // Byte opens a message; previous closes
   logic       msg_same, accept;        // Previous message repeated; accepted
   logic       mis_nxt, uns_nxt;        // Next defect states
   logic       status_rd;               // Status register read
   logic       proc_go;                 // Indirect access completes now
   logic [2:0] need;                    // Repeats needed

   assign len_last = ctrl_r.short_length_sel ? LAST_SHORT : LAST_LONG;
   assign need     = ctrl_r.persist_count_sel ? PERSIST_LONG : PERSIST_SHORT;
   assign status_rd = reg_rd_i && (reg_addr_i == STATUS_ADDR);
   // Capture writes own the buffers; any indirect access waits while rx_valid_i is high
   assign proc_go  = busy_r && (busy_cnt_r == 7'h01) && !rx_valid_i;

   // Locate the arriving byte within the message
   always_comb begin
      idx = (wptr_r > len_last) ? 6'h00 : wptr_r;
      if (ctrl_r.align_disable) begin
         idx = idx;
      end else if (ctrl_r.short_length_sel) begin
         if (rx_byte_i[7]) idx = 6'h00;
      end else if (prev2_r == CHAR_CR && prev1_r == CHAR_LF) begin
         idx = 6'h00;
      end
   end

   assign msg_start = rx_valid_i && (idx == 6'h00);
   assign msg_done  = msg_start && started_r;
   assign msg_same  = !acc_diff_prev_r;
   assign accept    = msg_done && msg_same && (rep_cnt_r + 3'h1 >= need);

   // Next defect states from a closing message
   always_comb begin
      mis_nxt = mis_state_r;
      uns_nxt = uns_state_r;
      if (accept) begin
         uns_nxt = 1'b0;
         if (ctrl_r.zero_message_consider || acc_nonzero_r)
            mis_nxt = acc_diff_exp_r;
      end else if (msg_done && !msg_same && (chg_cnt_r + 4'h1 >= UNSTABLE_COUNT)) begin
         uns_nxt = 1'b1;
      end
   end

   // Capture pointer and alignment history
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wptr_r    <= 6'h00;
         prev1_r   <= 8'h00;
         prev2_r   <= 8'h00;
         started_r <= 1'b0;
      end else if (rx_valid_i) begin
         wptr_r    <= (idx == len_last) ? 6'h00 : idx + 6'h01;
         prev1_r   <= rx_byte_i;
         prev2_r   <= prev1_r;
         started_r <= 1'b1;
      end
   end

   // Per-message comparison accumulators, restarted with each new message
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         acc_diff_prev_r <= 1'b0;
         acc_diff_exp_r  <= 1'b0;
         acc_nonzero_r   <= 1'b0;
      end else if (rx_valid_i) begin
         acc_diff_prev_r <= (rx_byte_i != cap_mem[idx]) || (!msg_start && acc_diff_prev_r);
         acc_diff_exp_r  <= (rx_byte_i != exp_mem[idx]) || (!msg_start && acc_diff_exp_r);
         acc_nonzero_r   <= (rx_byte_i != 8'h00) || (!msg_start && acc_nonzero_r);
      end
   end

   // Repeat and change counters, both saturating
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rep_cnt_r <= 3'h0;
         chg_cnt_r <= 4'h0;
      end else if (msg_done) begin
         if (msg_same) begin
            if (rep_cnt_r < need) rep_cnt_r <= rep_cnt_r + 3'h1;
            chg_cnt_r <= 4'h0;
         end else begin
            rep_cnt_r <= 3'h1;
            if (chg_cnt_r < UNSTABLE_COUNT) chg_cnt_r <= chg_cnt_r + 4'h1;
         end
      end
   end

   // Defect states and sticky change flags; a new change beats a read clear
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mis_state_r <= 1'b0;
         uns_state_r <= 1'b0;
         mis_flag_r  <= 1'b0;
         uns_flag_r  <= 1'b0;
      end else begin
         mis_state_r <= mis_nxt;
         uns_state_r <= uns_nxt;
         mis_flag_r  <= (mis_nxt != mis_state_r) || (mis_flag_r && !status_rd);
         uns_flag_r  <= (uns_nxt != uns_state_r) || (uns_flag_r && !status_rd);
      end
   end

   // Interrupt output; mask bits gate the sticky flags
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) irq_out_n_o <= 1'b1;
      else irq_out_n_o <= !((mis_flag_r && ctrl_r.mismatch_irq_en) ||
                            (uns_flag_r && ctrl_r.unstable_irq_en));
   end

   assign trace_mismatch_defect_o = mis_state_r;  // Straight from state flop

   // Buffer writes: capture stream and completed indirect writes.
   // Not reset: contents are defined by traffic and software only.
   always_ff @(posedge sys_clk_i) begin
      if (rx_valid_i) cap_mem[idx] <= rx_byte_i;
      if (proc_go && !ind_addr_r.indirect_read_sel) begin
         if (ctrl_r.rx_buffer_select) begin
            if (ind_addr_r.addr[6]) exp_mem[ind_addr_r.addr[5:0]] <= ind_data_r;
            else cap_mem[ind_addr_r.addr[5:0]] <= ind_data_r;
         end else if (!ind_addr_r.addr[6]) begin
            tx_mem[ind_addr_r.addr[5:0]] <= ind_data_r;         // Upper half unused
         end
      end
   end

   // Control and indirect address registers
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_r     <= ctrl_t'(CTRL_RESET);
         ind_addr_r <= ind_addr_t'(IND_RESET);
      end else if (reg_wr_i) begin
         if (reg_addr_i == CTRL_ADDR) ctrl_r <= ctrl_t'(reg_wdata_i);
         if (reg_addr_i == IND_ADDR_ADDR) ind_addr_r <= ind_addr_t'(reg_wdata_i);
      end
   end

   // Busy timer started by an address write
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         busy_r     <= 1'b0;
         busy_cnt_r <= 7'h00;
      end else if (reg_wr_i && reg_addr_i == IND_ADDR_ADDR) begin
         busy_r     <= 1'b1;
         busy_cnt_r <= BUSY_CYCLES;
      end else if (proc_go) begin
         busy_r     <= 1'b0;
         busy_cnt_r <= 7'h00;
      end else if (busy_r && busy_cnt_r > 7'h01) begin
         busy_cnt_r <= busy_cnt_r - 7'h01;
      end
   end

   // Indirect data: software writes it; a completed read loads it
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ind_data_r <= IND_RESET;
      end else if (proc_go && ind_addr_r.indirect_read_sel) begin
         if (ctrl_r.rx_buffer_select)
            ind_data_r <= ind_addr_r.addr[6] ? exp_mem[ind_addr_r.addr[5:0]]
                                             : cap_mem[ind_addr_r.addr[5:0]];
         else
            ind_data_r <= tx_mem[ind_addr_r.addr[5:0]];
      end else if (reg_wr_i && reg_addr_i == IND_DATA_ADDR) begin
         ind_data_r <= reg_wdata_i;
      end
   end

   // Read data for one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !reg_rd_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         unique case (reg_addr_i)
            CTRL_ADDR:     reg_rdata_o <= ctrl_r;
            STATUS_ADDR:   reg_rdata_o <= {busy_r, 3'h0, uns_flag_r, uns_state_r,
                                           mis_flag_r, mis_state_r};
            IND_ADDR_ADDR: reg_rdata_o <= ind_addr_r;
            IND_DATA_ADDR: reg_rdata_o <= ind_data_r;
            default:       reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // Transmit trace byte, one cycle after each request
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tx_ptr_r   <= 6'h00;
         tx_byte_o  <= 8'h00;
         tx_valid_o <= 1'b0;
      end else begin
         tx_valid_o <= tx_req_i;
         if (tx_req_i) begin
            tx_ptr_r <= (tx_ptr_r >= len_last) ? 6'h00 : tx_ptr_r + 6'h01;
            if (ctrl_r.tx_zero_message) tx_byte_o <= 8'h00;
            else tx_byte_o <= tx_mem[tx_ptr_r];
         end
      end
   end

   // Checks next to the logic they guard
   a_zero_tx_bytes: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      tx_req_i && ctrl_r.tx_zero_message |=> tx_valid_o && tx_byte_o == 8'h00)
      else $error("Zero message mode sent a nonzero byte");
   a_tx_from_buffer: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      tx_req_i && !ctrl_r.tx_zero_message |=> tx_byte_o == $past(tx_mem[tx_ptr_r]))
      else $error("Transmit byte not taken from buffer");
   a_short_align: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rx_valid_i && rx_byte_i[7] && ctrl_r.short_length_sel && !ctrl_r.align_disable
      |=> wptr_r == 6'h01)
      else $error("Marked byte not stored at location zero");
   a_long_align: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rx_valid_i && prev2_r == CHAR_CR && prev1_r == CHAR_LF && !ctrl_r.short_length_sel
      && !ctrl_r.align_disable |=> wptr_r == 6'h01)
      else $error("Byte after CR LF not stored at location zero");
   a_busy_length: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == IND_ADDR_ADDR |=> busy_r [*8])
      else $error("Busy dropped too early");
   a_busy_ends: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(busy_r) |-> ##[1:200] !busy_r)
      else $error("Busy never cleared");
   a_mis_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $changed(mis_state_r) |-> mis_flag_r)
      else $error("Mismatch change not flagged");
   a_uns_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $changed(uns_state_r) |-> uns_flag_r)
      else $error("Unstable change not flagged");
   a_accept_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      accept |=> !uns_state_r)
      else $error("Accepted message left unstable set");
   a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      mis_flag_r && ctrl_r.mismatch_irq_en |=> !irq_out_n_o)
      else $error("Interrupt not raised for enabled flag");
   c_accept: cover property (@(posedge sys_clk_i) disable iff (rst_i) accept);
   c_unstable: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(uns_state_r));
   c_mismatch: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(mis_state_r));
   c_ind_read: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      proc_go && ind_addr_r.indirect_read_sel);

endmodule

`default_nettype wire

// >>> tb_section_trace_processor.sv
`timescale 1ns/1ns
`default_nettype none

module tb_section_trace_processor;
   import trace_pkg::*;
   logic       clk = 1'b0; // System clock
   logic       rst;        // Reset
   logic       wr;         // Write strobe
   logic       rd;         // Read strobe
   logic       rx_valid;   // Received byte strobe
   logic       tx_req;     // Outgoing request
   logic       tx_valid;   // Outgoing strobe
   logic       defect;     // Mismatch state output
   logic       irq_n;      // Interrupt, active low
   logic [7:0] addr;       // Register address
   logic [7:0] wdata;      // Register write data
   logic [7:0] rdata;      // Register read data
   logic [7:0] rx_byte;    // Received byte
   logic [7:0] tx_byte;    // Outgoing byte
   int         num_errors; // Mismatch count
   int         checked;    // Comparison count

   // 100 MHz clock
   always #5 clk = ~clk;

   section_trace_processor i_section_trace_processor (
      .sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_byte_i(rx_byte),
      .rx_valid_i(rx_valid), .tx_req_i(tx_req), .tx_byte_o(tx_byte),
      .tx_valid_o(tx_valid), .trace_mismatch_defect_o(defect), .irq_out_n_o(irq_n));

   trace_overhead_model i_trace_overhead_model (
      .sys_clk_i(clk), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
      .tx_req_o(tx_req), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid));

   // Compare and report
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Register port cycles
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   // Indirect buffer access; polling status also clears the change flags
   task automatic ind_access(input logic rsel, input logic [6:0] a,
                             input logic [7:0] d, output logic [7:0] q);
      logic [7:0] st;
      if (!rsel) begin
         reg_write(IND_DATA_ADDR, d);
      end
      reg_write(IND_ADDR_ADDR, {rsel, a});
      st = 8'h80;
      for (int n = 0; n < 100 && st[ST_BUSY] !== 1'b0; n++) begin
         reg_read(STATUS_ADDR, st);
      end
      check(st[ST_BUSY], 8'h00);
      reg_read(IND_DATA_ADDR, q);
   endtask

   // Short messages: first byte carries the alignment msb
   function automatic logic [7:0] msg(input logic alt, input int i);
      return (i == 0) ? {7'h40, alt} : 8'(8'h20 + i);
   endfunction

   // Send len bytes of a message, then let the state update settle
   task automatic send_msg(input logic alt, input int len);
      for (int i = 0; i < len; i++) begin
         i_trace_overhead_model.send_byte(msg(alt, i), 1);
      end
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Send n all-zero short messages, then let the state update settle
   task automatic send_zero(input int n);
      for (int i = 0; i < 16 * n; i++) begin
         i_trace_overhead_model.send_byte(8'h00, 1);
      end
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic test_reset();
      logic [7:0] q;
      logic       v;
      reg_read(CTRL_ADDR, q);
      check(q, CTRL_RESET);
      reg_read(STATUS_ADDR, q);
      check(q & 8'h85, 8'h00);
      reg_write(8'h27, 8'hFF);
      reg_read(8'h27, q);
      check(q, 8'h00);
      i_trace_overhead_model.fetch_byte(q, v);
      check(q, 8'h00);
      check(v, 8'h01);
      check(irq_n, 8'h01);
   endtask

   task automatic test_transmit();
      ctrl_t      c;
      logic [7:0] q;
      logic [7:0] st;
      logic       v;
      int         n;
      c = CTRL_RESET;
      c.short_length_sel = 1'b1;
      reg_write(CTRL_ADDR, c);
      for (int i = 0; i < 16; i++) begin
         ind_access(1'b0, 7'(i), 8'(8'hA0 + i), q);
      end
      // Busy must stand about 0.6 us; each poll spans two cycles
      reg_write(IND_ADDR_ADDR, 8'h85);
      n  = 0;
      st = 8'h80;
      while (st[ST_BUSY] !== 1'b0 && n < 100) begin
         reg_read(STATUS_ADDR, st);
         n++;
      end
      check(8'(n >= 28 && n <= 31), 8'h01);
      reg_read(IND_DATA_ADDR, q);
      check(q, 8'hA5);
      c.tx_zero_message = 1'b0;
      reg_write(CTRL_ADDR, c);
      i_trace_overhead_model.fetch_byte(st, v);
      check(st[7:4], 8'h0A);
      // Wrap after sixteen bytes in short mode
      for (int i = 0; i < 20; i++) begin
         i_trace_overhead_model.fetch_byte(q, v);
         check(q, {4'hA, st[3:0] + 4'h1});
         st = q;
      end
      c.tx_zero_message = 1'b1;
      reg_write(CTRL_ADDR, c);
      i_trace_overhead_model.fetch_byte(q, v);
      check(q, 8'h00);
   endtask

   task automatic test_receive();
      ctrl_t      c;
      logic [7:0] q;
      c = CTRL_RESET;
      c.short_length_sel = 1'b1;
      c.rx_buffer_select = 1'b1;
      c.mismatch_irq_en  = 1'b1;
      reg_write(CTRL_ADDR, c);
      for (int i = 0; i < 16; i++) begin
         ind_access(1'b0, 7'(64 + i), msg(1'b0, i), q);
      end
      // Differing message accepted at the third closure
      for (int k = 1; k <= 4; k++) begin
         send_msg(1'b1, 16);
         check(defect, 8'(k == 4));
      end
      check(irq_n, 8'h00);
      reg_read(STATUS_ADDR, q);
      check(q & 8'h8F, 8'h03);
      reg_read(STATUS_ADDR, q);
      check(q & 8'h8F, 8'h01);
      check(irq_n, 8'h01);
      // Matching message needs five closures now
      c.persist_count_sel = 1'b1;
      reg_write(CTRL_ADDR, c);
      for (int k = 1; k <= 6; k++) begin
         send_msg(1'b0, (k == 6) ? 1 : 16);
         check(defect, 8'(k < 6));
      end
      reg_read(STATUS_ADDR, q);
      check(q & 8'h8F, 8'h02);
      ind_access(1'b1, 7'h00, 8'h00, q);
      check(q, 8'h80);
      ind_access(1'b1, 7'h01, 8'h00, q);
      check(q, 8'h21);
      ind_access(1'b1, 7'h40, 8'h00, q);
      check(q, 8'h80);
   endtask

   // Alternating messages go unstable at the eighth change
   task automatic test_unstable();
      ctrl_t      c;
      logic [7:0] q;
      c = CTRL_RESET;
      c.short_length_sel = 1'b1;
      c.unstable_irq_en  = 1'b1;
      reg_write(CTRL_ADDR, c);
      for (int k = 1; k <= 9; k++) begin
         send_msg(1'(k % 2), 16);
         if (k >= 8) check(irq_n, 8'(k == 8));
      end
      reg_read(STATUS_ADDR, q);
      check(q & 8'h8F, 8'h0C);
      reg_read(STATUS_ADDR, q);
      check(q & 8'h8F, 8'h04);
      check(irq_n, 8'h01);
      // Three repeats accept the message and end instability
      for (int k = 0; k < 3; k++) begin
         send_msg(1'b1, 16);
      end
      reg_read(STATUS_ADDR, q);
      check(q & 8'h8F, 8'h0B);
   endtask

   // Zero messages, circular capture and long alignment
   task automatic test_zero_align();
      ctrl_t      c;
      logic [7:0] q;
      c = CTRL_RESET;
      c.short_length_sel = 1'b1;
      c.align_disable    = 1'b1;
      c.rx_buffer_select = 1'b1;
      c.mismatch_irq_en  = 1'b1;
      reg_write(CTRL_ADDR, c);
      // Matching message accepted at the third closure clears the defect
      for (int k = 0; k < 4; k++) begin
         send_msg(1'b0, 16);
      end
      check(defect, 8'h00);
      // Accepted all-zero message is ignored while not considered
      send_zero(4);
      check(defect, 8'h00);
      reg_read(STATUS_ADDR, q);
      check(q & 8'h8F, 8'h02);
      c.zero_message_consider = 1'b1;
      reg_write(CTRL_ADDR, c);
      send_zero(1);
      check(defect, 8'h01);
      check(irq_n, 8'h00);
      // Circular capture puts the marked byte at location two
      send_msg(1'b1, 2);
      send_msg(1'b1, 1);
      ind_access(1'b1, 7'h02, 8'h00, q);
      check(q, 8'h81);
      // Long aligned capture: byte after CR LF lands at location zero
      c.short_length_sel = 1'b0;
      c.align_disable    = 1'b0;
      reg_write(CTRL_ADDR, c);
      i_trace_overhead_model.send_byte(CHAR_CR, 1);
      i_trace_overhead_model.send_byte(CHAR_LF, 1);
      i_trace_overhead_model.send_byte(8'h55, 1);
      ind_access(1'b1, 7'h00, 8'h00, q);
      check(q, 8'h55);
   endtask

   // Reset again in mid-run: state and outputs return to reset values
   task automatic test_midrun_reset();
      logic [7:0] q;
      check(defect, 8'h01);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      check(defect, 8'h00);
      check(irq_n, 8'h01);
      reg_read(CTRL_ADDR, q);
      check(q, CTRL_RESET);
      reg_read(STATUS_ADDR, q);
      check(q, 8'h00);
   endtask

   // Main sequence
   initial begin
      rst        = 1'b1;
      wr         = 1'b0;
      rd         = 1'b0;
      addr       = 8'h00;
      wdata      = 8'h00;
      num_errors = 0;
      checked    = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_transmit();
      test_receive();
      test_unstable();
      test_zero_align();
      test_midrun_reset();
      finish_test();
   end

   // Watchdog, well beyond the few thousand cycles the tests need
   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      $display("Watchdog expired at %0t ns", $time);
      finish_test();
   end
endmodule

`default_nettype wire

// >>> trace_overhead_model.sv
`timescale 1ns/1ns
`default_nettype none

// Stand-in for the receive and transmit overhead processors
module trace_overhead_model (
   input  wire logic       sys_clk_i,  // System clock
   output logic      [7:0] rx_byte_o,  // Received trace byte
   output logic            rx_valid_o, // Received byte strobe
   output logic            tx_req_o,   // Outgoing byte request
   input  wire logic [7:0] tx_byte_i,  // Outgoing trace byte
   input  wire logic       tx_valid_i  // Outgoing byte strobe
);
   // Quiet stream at time zero
   initial begin
      rx_byte_o  = 8'h00;
      rx_valid_o = 1'b0;
      tx_req_o   = 1'b0;
   end

   // One received byte; afterwards the line shows the inverse so a stale
   // value can never be mistaken for fresh data
   task automatic send_byte(input logic [7:0] b, input int gap);
      @(posedge sys_clk_i);
      rx_byte_o  <= b;
      rx_valid_o <= 1'b1;
      @(posedge sys_clk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o  <= ~b;
      repeat (gap) @(posedge sys_clk_i);
   endtask

   // One outgoing byte, taken in the single cycle its strobe stands
   task automatic fetch_byte(output logic [7:0] b, output logic v);
      @(posedge sys_clk_i);
      tx_req_o <= 1'b1;
      @(posedge sys_clk_i);
      tx_req_o <= 1'b0;
      #1;
      b = tx_byte_i;
      v = tx_valid_i;
   endtask
endmodule

`default_nettype wire

// >>> trace_pkg.sv
`default_nettype none

package trace_pkg;
   // Register offsets on the byte-wide register port
   localparam logic [7:0] CTRL_ADDR      = 8'h28;   // Control register
   localparam logic [7:0] STATUS_ADDR    = 8'h29;   // Status register
   localparam logic [7:0] IND_ADDR_ADDR  = 8'h2A;   // Indirect address register
   localparam logic [7:0] IND_DATA_ADDR  = 8'h2B;   // Indirect data register
   // Reset values
   localparam logic [7:0] CTRL_RESET     = 8'h04;   // Zero message sent after reset
   localparam logic [7:0] IND_RESET      = 8'h00;   // Indirect registers clear
   // Status field positions
   localparam int         ST_BUSY        = 7;       // Indirect access pending
   localparam int         ST_UNS_FLAG    = 3;       // Unstable change flag
   localparam int         ST_UNS_STATE   = 2;       // Unstable state
   localparam int         ST_MIS_FLAG    = 1;       // Mismatch change flag
   localparam int         ST_MIS_STATE   = 0;       // Mismatch state
   // Message layout
   localparam logic [5:0] LAST_SHORT     = 6'h0F;   // Last index, 16-byte message
   localparam logic [5:0] LAST_LONG      = 6'h3F;   // Last index, 64-byte message
   localparam logic [7:0] CHAR_CR        = 8'h0D;   // Carriage return
   localparam logic [7:0] CHAR_LF        = 8'h0A;   // Linefeed
   // Persistence and instability counts
   localparam logic [2:0] PERSIST_LONG   = 3'h5;    // Repeats needed when selected
   localparam logic [2:0] PERSIST_SHORT  = 3'h3;    // Repeats needed otherwise
   localparam logic [3:0] UNSTABLE_COUNT = 4'h8;    // Changed messages to go unstable
   // Indirect access time
   localparam int         CLK_PERIOD_NS  = 10;      // 100 MHz system clock
   localparam int         BUSY_TIME_NS   = 600;     // Indirect access duration
   localparam logic [6:0] BUSY_CYCLES    = 7'((BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Control register layout, msb first
   typedef struct packed {
      logic zero_message_consider;  // All-zero messages count toward defect
      logic rx_buffer_select;       // Indirect access targets receive buffer
      logic unstable_irq_en;        // Unstable change drives interrupt
      logic mismatch_irq_en;        // Mismatch change drives interrupt
      logic persist_count_sel;      // Five repeats instead of three
      logic tx_zero_message;        // Send all-zero bytes
      logic align_disable;          // Plain circular capture
      logic short_length_sel;       // 16-byte message
   } ctrl_t;

   // Indirect address register layout
   typedef struct packed {
      logic       indirect_read_sel; // One reads, zero writes
      logic [6:0] addr;              // Buffer location
   } ind_addr_t;
endpackage

`default_nettype wire
